// ==== hdl/bmd_pkg.sv ====
// Constants for the base mismatch and diagnostics block
// Assumes a 32-bit Avalon-MM register bus with word addressing by byte offset
package bmd_pkg;
  // ****************************************************
  // Register map (byte offsets)
  // ****************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_EXPECT  = 8'h04;
  localparam logic [7:0] OFS_ACTUAL  = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_MAPS    = 8'h10;
  localparam logic [7:0] OFS_DIAGSEL = 8'h14;
  localparam logic [7:0] OFS_DIAGDAT = 8'h18;
  localparam logic [7:0] OFS_OUTCMD  = 8'h1c;
  localparam logic [7:0] OFS_INRAW   = 8'h20;
  localparam logic [7:0] OFS_IOSTATE = 8'h24;
  localparam logic [7:0] OFS_SLOTSEL = 8'h28;
  // ****************************************************
  // Control register fields
  // ****************************************************
  localparam int CTL_TOL     = 0;
  localparam int CTL_RUN     = 1;
  localparam int CTL_PARAM   = 2;
  localparam int CTL_OTHER   = 3;
  localparam int CTL_PRMERR  = 4;
  localparam int CTL_UNSUP   = 5;
  localparam int CTL_SYNC    = 6;
  localparam int CTL_FRZ     = 7;
  localparam int CTL_RPORT   = 8;
  localparam int CTL_COMM    = 9;
  localparam int CTL_MADDR   = 16;
  localparam int CTL_W       = 24;
  localparam logic [CTL_W-1:0] CTL_RESET = 24'hff0000;
  // ****************************************************
  // Diagnostic frame constants
  // ****************************************************
  localparam int            DIAG_LEN     = 15;
  localparam logic [7:0]    NO_MASTER    = 8'hff;
  localparam logic [7:0]    HDR_DEVICE   = 8'h06;
  localparam logic [7:0]    HDR_IDENT    = 8'h43;
  localparam logic [15:0]   IDENT_CODE   = 16'h5a5a; // Arbitrary value
  // ****************************************************
  // Display codes
  // ****************************************************
  localparam logic [3:0] DSP_OK     = 4'h0;
  localparam logic [3:0] DSP_REMOVE = 4'h2;
  localparam logic [3:0] DSP_STOP   = 4'h3;
  // Flicker divider: 20 MHz / 2^22, top bit toggles about every 0.1 s
  localparam int FLK_BITS = 22;
  // Slot entry: bit 8 = present, bits 7:0 = type code
  localparam int TYPE_W  = 8;
  localparam int ENTRY_W = 9;
  localparam int NSLOT   = 16;
endpackage

// ==== hdl/bmd_top.sv ====
// Base mismatch detection, output policy, display and diagnostic frame
// Assumes Avalon-MM master on CLK; hold-select strap and module-fail lines are pins
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: Compare master slot configuration with present modules; flag differences.
// R2: Tolerance off, configured module removed: display 2, offline, outputs per hold select.
// R3: Tolerance off, wrong module: offline, outputs per hold select, display 3/2 alternating.
// R4: Module in slot configured empty is ignored; display 0; normal operation.
// R5: Tolerance on, module removed: display 2; other slots exchange data normally.
// R6: Tolerance on, wrong type: ignored, display alternates 3/2, others normal.
// R7: Master stops bus: display 3, outputs per hold select, inputs forced off.
// R8: Diagnostic frame is exactly 15 bytes, bit 7 most significant.
// R9: Byte 1 holds the station status-one flags in documented order.
// R10: Byte 2: inactive 0, sync, freeze, constant 1, constant 0, awaiting parameters.
// R11: Byte 3 bit 7 is zero; the rest reserved.
// R12: Byte 4 is parameterizing master address, or 255 if none.
// R13: Bytes 5 and 6 carry the fixed maker identifier.
// R14: Byte 7 is device header 0x06.
// R15: Byte 8 bit 0 is remote port request pending; bytes 9, 10 reserved.
// R16: Bytes 11, 12 are the type-mismatch bitmap, slot 1 at byte 11 bit 0.
// R17: Byte 13 is identifier header 0x43.
// R18: Bytes 14, 15 flag slots with failed module or mismatched type.
// R19: Master counts failures on each loss and continuously during mismatch.
// R20: Master keeps seven presence words; bit 1 means absent, failed or offline.
// R21: Master keeps seven enable words; 1 enabled, 0 disabled.
// R22: Master status word bits 1, 2, 16 and unread-diagnostic flag words.
// R23: Hold select off clears outputs on loss, hold keeps them; absent means off.
// R24: Tolerance off needs exact match for any I/O; decimal point lit when on.
// R25: Any mismatch bitmap bit sets extended-diagnostic and configuration-error flags.
module bmd_top #(
  parameter int NSLOT    = bmd_pkg::NSLOT,
  parameter int FLK_BITS = bmd_pkg::FLK_BITS
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic [7:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic [3:0]       AVS_BYTEENABLE,
  output logic [31:0]           AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  input  wire logic             OUTPUT_HOLD_SELECT_N,
  input  wire logic [NSLOT-1:0] MODULE_FAIL,
  output logic [NSLOT-1:0]      SLOT_ENABLE,
  output logic                  BASE_ONLINE,
  output logic [3:0]            DISPLAY_CODE,
  output logic                  DISPLAY_DP
);
  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic             hold_m_r, hold_s_r;
  logic [NSLOT-1:0] fail_m_r, fail_s_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold_m_r <= 1'b1;
      hold_s_r <= 1'b1;
      fail_m_r <= '0;
      fail_s_r <= '0;
    end else begin
      hold_m_r <= OUTPUT_HOLD_SELECT_N;
      hold_s_r <= hold_m_r;
      fail_m_r <= MODULE_FAIL;
      fail_s_r <= fail_m_r;
    end
  end
  // Strap low = hold; open pin pulls high = off
  wire hold_sel = ~hold_s_r; // R23

  // ****************************************************
  // Registers
  // ****************************************************
  logic [bmd_pkg::CTL_W-1:0]   ctrl_r;
  logic [bmd_pkg::ENTRY_W-1:0] expect_r [NSLOT];
  logic [bmd_pkg::ENTRY_W-1:0] actual_r [NSLOT];
  logic [3:0]                  slot_sel_r;
  logic [3:0]                  diag_sel_r;
  logic [31:0]                 out_cmd_r;
  logic [31:0]                 in_raw_r;
  logic [31:0]                 out_live_r;
  logic [31:0]                 in_rep_r;
  logic [31:0]                 rdata_nxt;
  logic                        ack_r;

  wire req   = (AVS_READ | AVS_WRITE) & ~ack_r;
  wire wr_go = AVS_WRITE & ack_r;

  // One wait cycle, answer on the second edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~req;
    end
  end

  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r     <= bmd_pkg::CTL_RESET;
      slot_sel_r <= '0;
      diag_sel_r <= '0;
      out_cmd_r  <= '0;
      in_raw_r   <= '0;
    end else if (wr_go) begin
      case (AVS_ADDRESS)
        bmd_pkg::OFS_CTRL: begin
          ctrl_r <= 24'(bmerge(32'(ctrl_r), AVS_WRITEDATA, AVS_BYTEENABLE));
        end
        bmd_pkg::OFS_SLOTSEL: begin
          slot_sel_r <= AVS_WRITEDATA[3:0];
        end
        bmd_pkg::OFS_DIAGSEL: begin
          diag_sel_r <= AVS_WRITEDATA[3:0];
        end
        bmd_pkg::OFS_OUTCMD: begin
          out_cmd_r <= bmerge(out_cmd_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        bmd_pkg::OFS_INRAW: begin
          in_raw_r <= bmerge(in_raw_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
        default: begin
        end
      endcase
    end
  end

  // Slot tables, one entry per slot, written through the slot select
  generate
    for (genvar s = 0; s < NSLOT; s++) begin : g_tab
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          expect_r[s] <= '0;
          actual_r[s] <= '0;
        end else if (wr_go && slot_sel_r == 4'(s)) begin
          if (AVS_ADDRESS == bmd_pkg::OFS_EXPECT) begin
            expect_r[s] <= AVS_WRITEDATA[bmd_pkg::ENTRY_W-1:0];
          end
          if (AVS_ADDRESS == bmd_pkg::OFS_ACTUAL) begin
            actual_r[s] <= AVS_WRITEDATA[bmd_pkg::ENTRY_W-1:0];
          end
        end
      end
    end
  endgenerate

  // ****************************************************
  // Mismatch detection
  // ****************************************************
  logic [NSLOT-1:0] removed, wrong, type_map, fail_map, slot_ok;
  generate
    for (genvar s = 0; s < NSLOT; s++) begin : g_cmp
      wire exp_p = expect_r[s][bmd_pkg::TYPE_W];
      wire act_p = actual_r[s][bmd_pkg::TYPE_W];
      wire tdiff = expect_r[s][bmd_pkg::TYPE_W-1:0] != actual_r[s][bmd_pkg::TYPE_W-1:0];
      assign removed[s]  = exp_p & ~act_p;          // R1
      assign wrong[s]    = exp_p & act_p & tdiff;   // R1
      // Extra module in empty slot is not a mismatch
      assign slot_ok[s]  = exp_p & act_p & ~tdiff;  // R4
      assign type_map[s] = wrong[s];                // R16
      assign fail_map[s] = wrong[s] | removed[s] | (exp_p & fail_s_r[s]); // R18
    end
  endgenerate

  wire tol      = ctrl_r[bmd_pkg::CTL_TOL];
  wire run      = ctrl_r[bmd_pkg::CTL_RUN];
  wire any_rem  = |removed;
  wire any_wr   = |wrong;
  wire mismatch = any_rem | any_wr;
  wire comm_ok  = ctrl_r[bmd_pkg::CTL_COMM];
  // Exact match needed unless tolerance is on
  wire online   = run & comm_ok & (tol | ~mismatch); // R2 R3 R24

  // ****************************************************
  // Slot enables and online status
  // ****************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SLOT_ENABLE <= '0;
      BASE_ONLINE <= 1'b0;
    end else begin
      BASE_ONLINE <= online;
      SLOT_ENABLE <= online ? slot_ok : '0; // R5 R6
    end
  end

  // ****************************************************
  // Output and input policy
  // ****************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_live_r <= '0;
    end else if (online) begin
      out_live_r <= out_cmd_r;
    end else if (!hold_sel) begin
      out_live_r <= '0; // R2 R3 R7 R23
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_rep_r <= '0;
    end else if (!run) begin
      in_rep_r <= '0; // R7
    end else if (online) begin
      in_rep_r <= in_raw_r;
    end
  end

  // ****************************************************
  // Display
  // ****************************************************
  logic [FLK_BITS-1:0] flk_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flk_r <= '0;
    end else begin
      flk_r <= flk_r + 1'b1;
    end
  end

  logic [3:0] disp_nxt;
  always_comb begin
    if (!run || !comm_ok) begin
      disp_nxt = bmd_pkg::DSP_STOP;                           // R7
    end else if (any_wr) begin
      disp_nxt = flk_r[FLK_BITS-1] ? bmd_pkg::DSP_STOP
                                   : bmd_pkg::DSP_REMOVE;     // R3 R6
    end else if (any_rem) begin
      disp_nxt = bmd_pkg::DSP_REMOVE;                         // R2 R5
    end else begin
      disp_nxt = bmd_pkg::DSP_OK;                             // R4
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DISPLAY_CODE <= bmd_pkg::DSP_OK;
      DISPLAY_DP   <= 1'b0;
    end else begin
      DISPLAY_CODE <= disp_nxt;
      DISPLAY_DP   <= tol; // R24
    end
  end

  // ****************************************************
  // Diagnostic frame
  // ****************************************************
  logic [7:0] diag [bmd_pkg::DIAG_LEN];
  wire param_ok = ctrl_r[bmd_pkg::CTL_PARAM];
  wire ext_flag = |type_map | |fail_map; // R25
  always_comb begin
    diag[0] = {ctrl_r[bmd_pkg::CTL_OTHER], ctrl_r[bmd_pkg::CTL_PRMERR], 1'b0,
               ctrl_r[bmd_pkg::CTL_UNSUP], ext_flag, ext_flag,
               ~online, 1'b0};                                             // R9 R25
    diag[1] = {1'b0, 1'b0, ctrl_r[bmd_pkg::CTL_SYNC], ctrl_r[bmd_pkg::CTL_FRZ],
               1'b0, 1'b1, 1'b0, ~param_ok};                               // R10
    diag[2] = 8'h00;                                                       // R11
    diag[3] = param_ok ? ctrl_r[bmd_pkg::CTL_MADDR +: 8] : bmd_pkg::NO_MASTER; // R12
    diag[4] = bmd_pkg::IDENT_CODE[15:8];                                   // R13
    diag[5] = bmd_pkg::IDENT_CODE[7:0];                                    // R13
    diag[6] = bmd_pkg::HDR_DEVICE;                                         // R14
    diag[7] = {7'h00, ctrl_r[bmd_pkg::CTL_RPORT]};                         // R15
    diag[8] = 8'h00;                                                       // R15
    diag[9] = 8'h00;                                                       // R15
    diag[10] = type_map[7:0];                                              // R16
    diag[11] = type_map[15:8];                                             // R16
    diag[12] = bmd_pkg::HDR_IDENT;                                         // R17
    diag[13] = fail_map[7:0];                                              // R18
    diag[14] = fail_map[15:8];                                             // R18
  end

  // ****************************************************
  // Read mux
  // ****************************************************
  always_comb begin
    rdata_nxt = '0;
    case (AVS_ADDRESS)
      bmd_pkg::OFS_CTRL:    rdata_nxt = 32'(ctrl_r);
      bmd_pkg::OFS_EXPECT:  rdata_nxt = 32'(expect_r[slot_sel_r]);
      bmd_pkg::OFS_ACTUAL:  rdata_nxt = 32'(actual_r[slot_sel_r]);
      bmd_pkg::OFS_STATUS:  rdata_nxt = {24'h000000, DISPLAY_DP, 1'b0, any_wr, any_rem,
                                         DISPLAY_CODE};
      bmd_pkg::OFS_MAPS:    rdata_nxt = {fail_map, type_map};
      // Frame is 15 bytes; selects past the end read zero
      bmd_pkg::OFS_DIAGDAT: rdata_nxt = (diag_sel_r < 4'(bmd_pkg::DIAG_LEN))
                                        ? {24'h000000, diag[diag_sel_r]} : '0; // R8
      bmd_pkg::OFS_DIAGSEL: rdata_nxt = {28'h0000000, diag_sel_r};
      bmd_pkg::OFS_OUTCMD:  rdata_nxt = out_cmd_r;
      bmd_pkg::OFS_INRAW:   rdata_nxt = in_rep_r;
      bmd_pkg::OFS_IOSTATE: rdata_nxt = out_live_r;
      bmd_pkg::OFS_SLOTSEL: rdata_nxt = {28'h0000000, slot_sel_r};
      default:              rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AVS_READDATA <= '0;
    end else if (req) begin
      AVS_READDATA <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== dv/bmd_top_sva.sv ====
// Port checker for the base mismatch and diagnostics block
// Assumes it is bound onto bmd_top and sees its ports only
`timescale 1ns/100ps
`default_nettype none
module bmd_top_sva #(
  parameter int NSLOT    = bmd_pkg::NSLOT,
  parameter int FLK_BITS = bmd_pkg::FLK_BITS
) (
  input wire logic             CLK,
  input wire logic             RST,
  input wire logic             AVS_READ,
  input wire logic             AVS_WRITE,
  input wire logic [31:0]      AVS_READDATA,
  input wire logic             AVS_WAITREQUEST,
  input wire logic [NSLOT-1:0] SLOT_ENABLE,
  input wire logic             BASE_ONLINE,
  input wire logic [3:0]       DISPLAY_CODE,
  input wire logic             DISPLAY_DP
);
  // ********************
  // Port relations
  // ********************
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  answer_prompt_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered on the next edge");
  answer_cause_a: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
    else $error("waitrequest dropped without a request");
  rdata_hold_a: assert property (!(AVS_READ || AVS_WRITE) |=> $stable(AVS_READDATA))
    else $error("read data changed while idle");
  slot_gate_a: assert property (|SLOT_ENABLE |-> BASE_ONLINE || $past(BASE_ONLINE))
    else $error("slot exchanging data while base offline");
  offline_code_a: assert property (!BASE_ONLINE [*3] |-> DISPLAY_CODE != bmd_pkg::DSP_OK)
    else $error("offline base shows code 0");
  code_set_a: assert property (DISPLAY_CODE inside {4'h0, 4'h2, 4'h3})
    else $error("display code outside the used set");
  exact_ok_a: assert property ((BASE_ONLINE && !DISPLAY_DP) [*3] |-> DISPLAY_CODE == 4'h0)
    else $error("online strict base shows nonzero code");
  dp_quiet_a: assert property (!AVS_WRITE [*3] |=> $stable(DISPLAY_DP))
    else $error("decimal point changed without a write");
endmodule
bind bmd_top bmd_top_sva #(.NSLOT(NSLOT), .FLK_BITS(FLK_BITS)) u_sva (
  .CLK(CLK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SLOT_ENABLE(SLOT_ENABLE), .BASE_ONLINE(BASE_ONLINE),
  .DISPLAY_CODE(DISPLAY_CODE), .DISPLAY_DP(DISPLAY_DP));
`default_nettype wire

// ==== dv/bmd_master.sv ====
// Fieldbus master side model driving the register bus
// Assumes tasks are called from the bench on the one clock
`timescale 1ns/100ps
`default_nettype none
module bmd_master (
  input  wire logic        clk,
  input  wire logic        base_online,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable
);
  // ********************
  // Failure count and bus cycles
  // ********************
  localparam int ADDR = 3; // This slave's bus address
  localparam int WI   = (ADDR - 1) / 16;
  localparam int BI   = 15 - (ADDR - 1) % 16;
  int          fail_count   = 0;
  int          late_answers = 0;
  logic        online_d     = 1'b0;
  logic [15:0] slave_presence_words [7]   = '{default: 16'hffff};
  logic [15:0] slave_enable_words [7]     = '{default: 16'h0000};
  logic [15:0] unread_diag_flag_words [7] = '{default: 16'h0000};
  logic [15:0] bus_system_state_word      = 16'h0000;
  initial begin
    {address, read, write, writedata, byteenable} = '0;
    slave_enable_words[WI][BI] = 1'b1;
  end
  always @(posedge clk) begin
    if (!base_online) fail_count <= fail_count + 1;
  end
  always @(posedge clk) begin
    online_d <= base_online;
    slave_presence_words[WI][BI] <= !base_online;
    if (online_d && !base_online) begin
      unread_diag_flag_words[WI][BI] <= 1'b1;
    end else if (read && !waitrequest && address == bmd_pkg::OFS_DIAGDAT) begin
      unread_diag_flag_words[WI][BI] <= 1'b0;
    end
    if (write && !waitrequest && address == bmd_pkg::OFS_CTRL) begin
      bus_system_state_word <= {writedata[bmd_pkg::CTL_RUN], !writedata[bmd_pkg::CTL_RUN],
                                13'h0000, 1'b1};
    end
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    if (n != 1) late_answers++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the base mismatch and diagnostics block
// Assumes the master model in bmd_master and the bound port checker
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ********************
  // Stimulus, model and checks
  // ********************
  localparam int FLKB = 3;
  logic CLK, RST, hold_n, rd, wr, wait_r, online, dp;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be, code;
  logic [15:0] mfail, slot_en;
  int errors, n_compared, seed, c, i, k, run, tol, flags, maddr, v1, v2, raw, prm;
  int ep[16], et[16], ap[16], at[16];
  bmd_top #(.FLK_BITS(FLKB)) uut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r), .OUTPUT_HOLD_SELECT_N(hold_n), .MODULE_FAIL(mfail),
    .SLOT_ENABLE(slot_en), .BASE_ONLINE(online), .DISPLAY_CODE(code), .DISPLAY_DP(dp));
  bmd_master u_m (.clk(CLK), .base_online(online), .waitrequest(wait_r), .readdata(rdata),
    .address(addr), .read(rd), .write(wr), .writedata(wdata), .byteenable(be));
  task automatic complete_run();
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    u_m.acc(1'b1, a, d, q);
  endtask
  task automatic rreg(input string what, input logic [7:0] a, input logic [31:0] e);
    u_m.acc(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask
  task automatic put_slot(input int j);
    wreg(bmd_pkg::OFS_SLOTSEL, j);
    wreg(bmd_pkg::OFS_EXPECT, (ep[j] << 8) | et[j]);
    wreg(bmd_pkg::OFS_ACTUAL, (ap[j] << 8) | at[j]);
  endtask
  task automatic wctl();
    wreg(bmd_pkg::OFS_CTRL, (maddr << 16) | 32'h200 | (prm << 2) | flags | (run << 1) | tol);
  endtask
  function automatic logic [15:0] mapw(input int kind);
    logic [15:0] m;
    for (int j = 0; j < 16; j++)
      m[j] = kind ? (ep[j] && !ap[j]) : (ep[j] && ap[j] && et[j] != at[j]);
    return m;
  endfunction
  function automatic logic on_m();
    return run && (tol || (mapw(0) == 0 && mapw(1) == 0));
  endfunction
  function automatic logic [15:0] sen_m();
    logic [15:0] m;
    for (int j = 0; j < 16; j++) m[j] = on_m() && ep[j] && ap[j] && et[j] == at[j];
    return m;
  endfunction
  function automatic logic [7:0] dbyte(input int n);
    logic [15:0] tm, fm;
    tm = mapw(0);
    fm = mapw(1) | mfail | tm;
    case (n)
      0: return {flags[3], flags[4], 1'b0, flags[5], |fm, |fm, !on_m(), 1'b0};
      1: return {2'b00, flags[6], flags[7], 3'b010, !prm};
      3: return prm ? maddr[7:0] : 8'hff;
      4: return bmd_pkg::IDENT_CODE[15:8];
      5: return bmd_pkg::IDENT_CODE[7:0];
      6: return bmd_pkg::HDR_DEVICE;
      7: return {7'h0, flags[8]};
      10: return tm[7:0];
      11: return tm[15:8];
      12: return bmd_pkg::HDR_IDENT;
      13: return fm[7:0];
      14: return fm[15:8];
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk_disp();
    int n, s2, s3, dm, fc;
    fc = u_m.fail_count;
    n = 0;
    s2 = 0;
    s3 = 0;
    dm = !run ? 3 : mapw(1) != 0 ? 2 : mapw(0) != 0 ? 5 : 0;
    repeat (5 << FLKB) begin
      @(negedge CLK);
      n += (code === dm[3:0]);
      s2 += (code === 4'h2);
      s3 += (code === 4'h3);
    end
    chk("display", 1, dm == 5 ? (s2 > 0 && s3 > 0 && s2 + s3 == 5 << FLKB) : n == 5 << FLKB);
    chk("fail count", on_m() ? 0 : 5 << FLKB, u_m.fail_count - fc);
  endtask
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    repeat (30000) @(posedge CLK);
    errors++;
    complete_run();
  end
  initial begin
    {seed, errors, n_compared, run, tol, flags} = '0;
    seed = 11;
    maddr = 255;
    prm = 1;
    RST = 1'b1;
    hold_n = 1'b1;
    mfail = 16'h0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    repeat (2) @(negedge CLK);
    chk("display after reset", 3, code);
    rreg("ctrl reset", bmd_pkg::OFS_CTRL, bmd_pkg::CTL_RESET);
    wreg(8'h40, 32'h1);
    rreg("unmapped", 8'h40, 32'h0);
    for (i = 0; i < 16; i++) begin
      ep[i] = i < 14;
      et[i] = $random(seed) & 255;
      ap[i] = i != 14;
      at[i] = et[i];
      put_slot(i);
    end
    run = 1;
    wctl();
    raw = $random(seed);
    wreg(bmd_pkg::OFS_INRAW, raw);
    for (c = 0; c < 5; c++) begin
      tol = 0;
      run = 1;
      prm = 1;
      hold_n <= c != 1;
      mfail <= c == 2 ? 16'h0001 : 16'h0000;
      ap[2] = 1;
      at[4] = et[4];
      put_slot(2);
      put_slot(4);
      flags = $random(seed) & 32'h1f8;
      maddr = $random(seed) & 255;
      wctl();
      v1 = $random(seed);
      wreg(bmd_pkg::OFS_OUTCMD, v1);
      if (c == 0 || c == 3) ap[2] = 0;
      if (c == 1 || c == 2) at[4] = at[4] ^ 1;
      put_slot(2);
      put_slot(4);
      run = c != 4;
      tol = c == 2 || c == 3;
      prm = c != 3;
      wctl();
      v2 = $random(seed);
      wreg(bmd_pkg::OFS_OUTCMD, v2);
      chk_disp();
      chk("online", on_m(), online);
      chk("slot enable", sen_m(), slot_en);
      chk("decimal point", tol, dp);
      chk("presence bit", !on_m(), u_m.slave_presence_words[u_m.WI][u_m.BI]);
      chk("enable bit", 1, u_m.slave_enable_words[u_m.WI][u_m.BI]);
      chk("state word", {run[0], !run, 13'h0000, 1'b1}, u_m.bus_system_state_word);
      chk("diag signalled", 1, u_m.unread_diag_flag_words[u_m.WI][u_m.BI]);
      rreg("outputs", bmd_pkg::OFS_IOSTATE, on_m() ? v2 : !hold_n ? v1 : 0);
      rreg("inputs", bmd_pkg::OFS_INRAW, run ? raw : 0);
      for (k = 0; k < 16; k++) begin
        wreg(bmd_pkg::OFS_DIAGSEL, k);
        rreg("diag byte", bmd_pkg::OFS_DIAGDAT, dbyte(k));
      end
      chk("diag unread", 0, u_m.unread_diag_flag_words[u_m.WI][u_m.BI]);
    end
    chk("bus answer latency", 0, u_m.late_answers);
    complete_run();
  end
endmodule
`default_nettype wire
